// File: hdl/cifs_params.svh
// Constants for the CAN interrupt flag and error-state status block.
// Assumes inclusion by bare name from the package, ahead of the design.
`ifndef CIFS_PARAMS_SVH
`define CIFS_PARAMS_SVH

// Register byte addresses
`define CIFS_ADDR_FLAGS     12'h000
`define CIFS_ADDR_MASK      12'h004
`define CIFS_ADDR_IRQ       12'h008

// Flag register bit positions
`define CIFS_BIT_TXBOFF     13
`define CIFS_BIT_TXPASS     12
`define CIFS_BIT_RXPASS     11
`define CIFS_BIT_TXWARN     10
`define CIFS_BIT_RXWARN     9
`define CIFS_BIT_ANYWARN    8
`define CIFS_BIT_INVMSG     7
`define CIFS_BIT_WAKE       6
`define CIFS_BIT_ERR        5
`define CIFS_BIT_RSVD       4
`define CIFS_BIT_FIFO       3
`define CIFS_BIT_RXOVF      2
`define CIFS_BIT_RXBUF      1
`define CIFS_BIT_TXBUF      0

// Writable, clearable flag bits of the low byte
`define CIFS_FLAG_MASK      8'hEF
`define CIFS_FLAG_RESET     8'h00
`define CIFS_MASK_RESET     8'h00
`define CIFS_STATE_RESET    6'h00
`define CIFS_ZERO32         32'h0000_0000
`define CIFS_ZERO2          2'h0

`endif

// File: hdl/cifs_pkg.sv
// Types for the CAN interrupt flag and error-state status block.
// Assumes cifs_params.svh is on the include path.
`include "cifs_params.svh"

package cifs_pkg;

    // Error confinement levels from the protocol engine
    typedef struct packed {
        logic tx_bus_off_state;
        logic tx_bus_passive_state;
        logic rx_bus_passive_state;
        logic tx_warning_state;
        logic rx_warning_state;
    } cifs_err_state_t;

    // One-cycle event pulses from the protocol engine
    typedef struct packed {
        logic invalid_message;
        logic bus_wakeup;
        logic fifo_almost_full;
        logic rx_overflow;
        logic rx_buffer;
        logic tx_buffer;
    } cifs_events_t;

    typedef enum logic [1:0] {
        CIFS_IDLE   = 2'b00,
        CIFS_ACCESS = 2'b01
    } cifs_bus_state_t;

endpackage

// File: hdl/cifs_top.sv
// CAN interrupt flag and error-state status register behind an APB slave.
// Assumes state and event inputs synchronous to pclk; events are one-cycle pulses.
// Notes on behaviour
// - Bit 13 shows transmitter bus-off state
// - Bits 12, 11 show tx, rx passive
// - Bit 10 shows transmitter warning state
// - Bit 9 shows receiver warning state
// - Bit 8 is OR of both warnings
// - Events set flags at bits 7, 6, 3..0; bit 5 on error-state entry, bit 4 stays 0
// - Flags stick until software clears them
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module cifs_top
    import cifs_pkg::*;
(
    // Clock and reset
    input  wire logic            pclk,
    input  wire logic            presetn,
    // APB slave
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [11:0]     paddr,
    input  wire logic [31:0]     pwdata,
    input  wire logic [3:0]      pstrb,
    output logic      [31:0]     prdata,
    output logic                 pready,
    output logic                 pslverr,
    // Protocol engine side
    input  wire cifs_err_state_t err_state,
    input  wire cifs_events_t    events,
    // Interrupt
    output logic                 irq
);

    // Build the 16-bit register image
    function automatic logic [15:0] flags_image(input logic [5:0] st, input logic [7:0] fl);
        logic [15:0] v;
        v = 16'h0000;
        v[`CIFS_BIT_TXBOFF:`CIFS_BIT_ANYWARN] = st;
        v[7:0] = fl & `CIFS_FLAG_MASK;
        return v;
    endfunction

    // State bits
    logic [5:0]      state_r;
    logic [5:0]      state_nxt;
    logic [7:0]      flags_r;
    logic [7:0]      flags_nxt;
    logic [7:0]      mask_r;
    logic [7:0]      mask_nxt;
    logic            irq_r;
    logic            irq_nxt;
    // Bus state
    cifs_bus_state_t bus_r;
    cifs_bus_state_t bus_nxt;
    logic [31:0]     prdata_r;
    logic [31:0]     prdata_nxt;
    logic            pready_r;
    logic            pready_nxt;
    logic            pslverr_r;
    logic            pslverr_nxt;

    logic            wr_flags;
    logic            wr_mask;
    logic [7:0]      set_v;
    logic [7:0]      clr_v;
    logic            addr_ok;

    // Error-state image and event collection
    always_comb begin
        state_nxt = 6'h00;
        state_nxt[`CIFS_BIT_TXBOFF - `CIFS_BIT_ANYWARN] = err_state.tx_bus_off_state;
        state_nxt[`CIFS_BIT_TXPASS - `CIFS_BIT_ANYWARN] = err_state.tx_bus_passive_state;
        state_nxt[`CIFS_BIT_RXPASS - `CIFS_BIT_ANYWARN] = err_state.rx_bus_passive_state;
        state_nxt[`CIFS_BIT_TXWARN - `CIFS_BIT_ANYWARN] = err_state.tx_warning_state;
        state_nxt[`CIFS_BIT_RXWARN - `CIFS_BIT_ANYWARN] = err_state.rx_warning_state;
        state_nxt[0] = err_state.tx_warning_state | err_state.rx_warning_state;
        set_v = 8'h00;
        set_v[`CIFS_BIT_INVMSG] = events.invalid_message;
        set_v[`CIFS_BIT_WAKE]   = events.bus_wakeup;
        set_v[`CIFS_BIT_ERR]    = |(state_nxt & ~state_r);
        set_v[`CIFS_BIT_FIFO]   = events.fifo_almost_full;
        set_v[`CIFS_BIT_RXOVF]  = events.rx_overflow;
        set_v[`CIFS_BIT_RXBUF]  = events.rx_buffer;
        set_v[`CIFS_BIT_TXBUF]  = events.tx_buffer;
    end

    // APB decode
    always_comb begin
        addr_ok  = (paddr == `CIFS_ADDR_FLAGS) || (paddr == `CIFS_ADDR_MASK)
                   || (paddr == `CIFS_ADDR_IRQ);
        wr_flags = psel && penable && pready_r && pwrite && (paddr == `CIFS_ADDR_FLAGS);
        wr_mask  = psel && penable && pready_r && pwrite && (paddr == `CIFS_ADDR_MASK);
        clr_v    = 8'h00;
        if (wr_flags && pstrb[0]) begin
            clr_v = pwdata[7:0] & `CIFS_FLAG_MASK;
        end
    end

    // Flags, mask and interrupt next values; set wins over clear
    always_comb begin
        flags_nxt = ((flags_r & ~clr_v) | set_v) & `CIFS_FLAG_MASK;
        mask_nxt  = mask_r;
        if (wr_mask && pstrb[0]) begin
            mask_nxt = pwdata[7:0] & `CIFS_FLAG_MASK;
        end
        irq_nxt = |(flags_nxt & mask_nxt);
    end

    // Bus response: one wait state, ready in the second access cycle
    always_comb begin
        bus_nxt     = bus_r;
        prdata_nxt  = prdata_r;
        pready_nxt  = 1'b0;
        pslverr_nxt = 1'b0;
        unique case (bus_r)
            CIFS_IDLE: begin
                if (psel && penable) begin
                    bus_nxt     = CIFS_ACCESS;
                    pready_nxt  = 1'b1;
                    pslverr_nxt = !addr_ok;
                    prdata_nxt  = `CIFS_ZERO32;
                    if (!pwrite && paddr == `CIFS_ADDR_FLAGS) begin
                        prdata_nxt = {16'h0000, flags_image(state_r, flags_r)};
                    end else if (!pwrite && paddr == `CIFS_ADDR_MASK) begin
                        prdata_nxt = {24'h000000, mask_r};
                    end else if (!pwrite && paddr == `CIFS_ADDR_IRQ) begin
                        prdata_nxt = {31'h00000000, irq_r};
                    end
                end
            end
            CIFS_ACCESS: begin
                bus_nxt = CIFS_IDLE;
            end
            default: begin
                bus_nxt = CIFS_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r   <= `CIFS_STATE_RESET;
            flags_r   <= `CIFS_FLAG_RESET;
            mask_r    <= `CIFS_MASK_RESET;
            irq_r     <= 1'b0;
            bus_r     <= CIFS_IDLE;
            prdata_r  <= `CIFS_ZERO32;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            flags_r   <= flags_nxt;
            mask_r    <= mask_nxt;
            irq_r     <= irq_nxt;
            bus_r     <= bus_nxt;
            prdata_r  <= prdata_nxt;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;
    assign irq     = irq_r;

    // Checks: named steps of a bus access
    sequence s_access_start;
        psel && penable && !pready_r && (bus_r == CIFS_IDLE);
    endsequence

    sequence s_flags_read;
        psel && penable && !pwrite && (paddr == `CIFS_ADDR_FLAGS) && (bus_r == CIFS_IDLE);
    endsequence

    sequence s_flag_write;
        wr_flags && pstrb[0];
    endsequence

    sequence s_mask_write;
        wr_mask && pstrb[0];
    endsequence

    // Checks: confinement state image
    AST_TXBOFF: assert property (
        @(posedge pclk) disable iff (!presetn)
        state_r[`CIFS_BIT_TXBOFF - `CIFS_BIT_ANYWARN] == $past(err_state.tx_bus_off_state))
        else $error("bus-off bit wrong");

    AST_TXBOFF_READ: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_flags_read |=> prdata[`CIFS_BIT_TXBOFF]
            == $past(state_r[`CIFS_BIT_TXBOFF - `CIFS_BIT_ANYWARN]))
        else $error("bus-off bit read wrong");

    AST_TXPASS: assert property (
        @(posedge pclk) disable iff (!presetn)
        state_r[`CIFS_BIT_TXPASS - `CIFS_BIT_ANYWARN] == $past(err_state.tx_bus_passive_state))
        else $error("tx passive bit wrong");

    AST_RXPASS: assert property (
        @(posedge pclk) disable iff (!presetn)
        state_r[`CIFS_BIT_RXPASS - `CIFS_BIT_ANYWARN] == $past(err_state.rx_bus_passive_state))
        else $error("rx passive bit wrong");

    AST_PASS_READ: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_flags_read |=> prdata[`CIFS_BIT_RXPASS]
            == $past(state_r[`CIFS_BIT_RXPASS - `CIFS_BIT_ANYWARN]))
        else $error("rx passive bit read wrong");

    AST_TXWARN: assert property (
        @(posedge pclk) disable iff (!presetn)
        state_r[`CIFS_BIT_TXWARN - `CIFS_BIT_ANYWARN] == $past(err_state.tx_warning_state))
        else $error("tx warning bit wrong");

    AST_TXWARN_READ: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_flags_read |=> prdata[`CIFS_BIT_TXWARN]
            == $past(state_r[`CIFS_BIT_TXWARN - `CIFS_BIT_ANYWARN]))
        else $error("tx warning bit read wrong");

    AST_RXWARN: assert property (
        @(posedge pclk) disable iff (!presetn)
        state_r[`CIFS_BIT_RXWARN - `CIFS_BIT_ANYWARN] == $past(err_state.rx_warning_state))
        else $error("rx warning bit wrong");

    AST_RXWARN_READ: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_flags_read |=> prdata[`CIFS_BIT_RXWARN]
            == $past(state_r[`CIFS_BIT_RXWARN - `CIFS_BIT_ANYWARN]))
        else $error("rx warning bit read wrong");

    AST_ANYWARN: assert property (
        @(posedge pclk) disable iff (!presetn)
        state_r[`CIFS_BIT_ANYWARN - `CIFS_BIT_ANYWARN]
            == ($past(err_state.tx_warning_state) | $past(err_state.rx_warning_state)))
        else $error("combined warning wrong");

    AST_ANYWARN_READ: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_flags_read |=> prdata[`CIFS_BIT_ANYWARN]
            == (prdata[`CIFS_BIT_TXWARN] | prdata[`CIFS_BIT_RXWARN]))
        else $error("combined warning read wrong");

    // Checks: event flags
    AST_EVENT_SET: assert property (
        @(posedge pclk) disable iff (!presetn)
        events.rx_buffer |=> flags_r[`CIFS_BIT_RXBUF])
        else $error("event did not set flag");

    AST_EVENT_TXBUF: assert property (
        @(posedge pclk) disable iff (!presetn)
        events.tx_buffer |=> flags_r[`CIFS_BIT_TXBUF])
        else $error("tx buffer flag not set");

    AST_EVENT_RXOVF: assert property (
        @(posedge pclk) disable iff (!presetn)
        events.rx_overflow |=> flags_r[`CIFS_BIT_RXOVF])
        else $error("overflow flag not set");

    AST_EVENT_FIFO: assert property (
        @(posedge pclk) disable iff (!presetn)
        events.fifo_almost_full |=> flags_r[`CIFS_BIT_FIFO])
        else $error("almost full flag not set");

    AST_EVENT_WAKE: assert property (
        @(posedge pclk) disable iff (!presetn)
        events.bus_wakeup |=> flags_r[`CIFS_BIT_WAKE])
        else $error("wake flag not set");

    AST_EVENT_INVMSG: assert property (
        @(posedge pclk) disable iff (!presetn)
        events.invalid_message |=> flags_r[`CIFS_BIT_INVMSG])
        else $error("invalid message flag not set");

    AST_STICKY: assert property (
        @(posedge pclk) disable iff (!presetn)
        (flags_r[`CIFS_BIT_TXBUF] && !(wr_flags && pstrb[0] && pwdata[`CIFS_BIT_TXBUF]))
        |=> flags_r[`CIFS_BIT_TXBUF])
        else $error("flag lost without clear");

    AST_STICKY_ALL: assert property (
        @(posedge pclk) disable iff (!presetn)
        !(wr_flags && pstrb[0]) |=> ((flags_r & $past(flags_r)) == $past(flags_r)))
        else $error("flags lost without a write");

    AST_CLEAR: assert property (
        @(posedge pclk) disable iff (!presetn)
        (s_flag_write ##0 (pwdata[`CIFS_BIT_WAKE] && !events.bus_wakeup))
        |=> !flags_r[`CIFS_BIT_WAKE])
        else $error("flag not cleared");

    // Checks: error flag and unused bits
    AST_ERRSET: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(state_r[`CIFS_BIT_TXBOFF - `CIFS_BIT_ANYWARN]) |-> flags_r[`CIFS_BIT_ERR])
        else $error("error flag not set");

    AST_ERRSET_ANY: assert property (
        @(posedge pclk) disable iff (!presetn)
        (|(state_r & ~$past(state_r))) |-> flags_r[`CIFS_BIT_ERR])
        else $error("error flag not set on state entry");

    AST_BIT4: assert property (
        @(posedge pclk) disable iff (!presetn)
        !flags_r[`CIFS_BIT_RSVD])
        else $error("reserved bit set");

    AST_READ_RSVD: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_flags_read |=> (((prdata >> (`CIFS_BIT_TXBOFF + 1)) == '0)
            && !prdata[`CIFS_BIT_RSVD]))
        else $error("reserved bits read nonzero");

    // Checks: mask, interrupt and bus response
    AST_MASK_WRITE: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_mask_write |=> (mask_r == ($past(pwdata[7:0]) & `CIFS_FLAG_MASK)))
        else $error("mask write lost");

    AST_IRQ: assert property (
        @(posedge pclk) disable iff (!presetn)
        irq == |(flags_r & mask_r))
        else $error("irq mismatch");

    AST_READY_AFTER: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_access_start |=> pready)
        else $error("ready missing after access");

    AST_READY_PULSE: assert property (
        @(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("ready longer than one cycle");

    AST_SLVERR_READY: assert property (
        @(posedge pclk) disable iff (!presetn)
        pslverr |-> pready)
        else $error("error response without ready");

    AST_WRITE_ZERO: assert property (
        @(posedge pclk) disable iff (!presetn)
        (s_access_start ##0 pwrite) |=> (prdata == `CIFS_ZERO32))
        else $error("write returned data");

endmodule

`default_nettype wire

// File: test/cifs_engine_model.sv
// Protocol engine stand-in: drives confinement levels and event pulses.
// Assumes the bench calls its tasks between clock edges of pclk.
`timescale 1ns/1ps
`default_nettype none

module cifs_engine_model
    import cifs_pkg::*;
(
    // Clock
    input  wire logic      pclk,
    // Engine outputs
    output cifs_err_state_t err_state,
    output cifs_events_t    events
);
    initial begin
        err_state = '0;
        events    = '0;
    end

    // Confinement levels change after an edge and hold
    task automatic set_state(input logic [4:0] s);
        @(posedge pclk);
        err_state <= cifs_err_state_t'(s);
    endtask

    // Events last exactly one cycle
    task automatic pulse(input logic [5:0] e);
        @(posedge pclk);
        events <= cifs_events_t'(e);
        @(posedge pclk);
        events <= '0;
    endtask
endmodule

`default_nettype wire

// File: test/cifs_top_test.sv
// Self-checking bench for the flag and status block over APB.
// Assumes the engine model file and the design are compiled first.
`timescale 1ns/1ps
`default_nettype none

module cifs_top_test;
    import cifs_pkg::*;
    logic            pclk = 0;
    logic            presetn = 0;
    logic            psel = 0;
    logic            penable = 0;
    logic            pwrite = 0;
    logic [11:0]     paddr = '0;
    logic [31:0]     pwdata = '0;
    logic [3:0]      pstrb = 4'hF;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
    logic            irq;
    cifs_err_state_t err_state;
    cifs_events_t    events;
    logic [31:0]     rd;
    logic            er;
    int              n_errors = 0;
    int              samples_checked = 0;

    always #50 pclk = ~pclk;

    cifs_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .err_state(err_state), .events(events),
        .irq(irq));
    cifs_engine_model eng_u (.pclk(pclk), .err_state(err_state), .events(events));

    task automatic end_sim();
        $display("checked %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        i = 0;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1) begin
            n_errors++;
            end_sim();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    task automatic t_reset();
        apb(0, 12'h000, 32'h0); chk(rd, 32'h0);
        apb(0, 12'h004, 32'h0); chk(rd, 32'h0);
        apb(0, 12'h008, 32'h0); chk(rd, 32'h0);
        $display("done: reset");
    endtask

    task automatic t_state();
        logic [4:0] s;
        for (int k = 0; k < 5; k++) begin
            s = 5'h01 << k;
            eng_u.set_state(s);
            apb(0, 12'h000, 32'h0);
            chk(rd, {18'h0, s, s[1] | s[0], 8'h20});
            apb(1, 12'h000, 32'hFF);
            eng_u.set_state(5'h00);
            apb(0, 12'h000, 32'h0); chk(rd, 32'h0);
        end
        $display("done: state");
    endtask

    task automatic t_events();
        int bit_of [6] = '{0, 1, 2, 3, 6, 7};
        for (int k = 0; k < 6; k++) begin
            eng_u.pulse(6'h01 << k);
            apb(0, 12'h000, 32'h0); chk(rd, 32'h1 << bit_of[k]);
            apb(0, 12'h000, 32'h0); chk(rd, 32'h1 << bit_of[k]);
            apb(1, 12'h000, 32'h1 << bit_of[k]);
            apb(0, 12'h000, 32'h0); chk(rd, 32'h0);
        end
        $display("done: events");
    endtask

    task automatic t_irq();
        apb(1, 12'h004, 32'hFF);
        apb(0, 12'h004, 32'h0); chk(rd, 32'hEF);
        eng_u.pulse(6'h01);
        @(negedge pclk); chk({31'h0, irq}, 32'h1);
        apb(0, 12'h008, 32'h0); chk(rd, 32'h1);
        apb(1, 12'h004, 32'h0);
        @(negedge pclk); chk({31'h0, irq}, 32'h0);
        apb(1, 12'h004, 32'h01);
        @(negedge pclk); chk({31'h0, irq}, 32'h1);
        apb(1, 12'h000, 32'h01);
        @(negedge pclk); chk({31'h0, irq}, 32'h0);
        $display("done: irq");
    endtask

    task automatic t_refuse();
        apb(0, 12'h00C, 32'h0); chk({rd[30:0], er}, 32'h1);
        eng_u.pulse(6'h02);
        pstrb <= 4'h0;
        apb(1, 12'h000, 32'hFFFF);
        pstrb <= 4'hF;
        apb(0, 12'h000, 32'h0); chk(rd, 32'h02);
        apb(1, 12'h000, 32'hFFFF);
        apb(0, 12'h000, 32'h0); chk(rd, 32'h0);
        $display("done: refuse");
    endtask

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_state();
        t_events();
        t_irq();
        t_refuse();
        end_sim();
    end
endmodule

`default_nettype wire
